// ### logic/pullup_map.vh
// Behaviour
// - Register bits 5 and 4 enable the pullups of port A pins 5 and 4 when set, disable when clear.
// - Register bits 3 and 2 enable the pullups of port A pins 3 and 2 when set, disable when clear.
// - Register bits 1 and 0 enable the pullups of port A pins 1 and 0 when set, disable when clear.
// - A pin configured as high impedance, or as output other than I2C mode on pins 3 and 2, never gets its pullup, whatever its bit holds.
// - Pins 3 and 2 in I2C output mode driving high keep the pullup on when the bit is set.
// - Pins 3 and 2 in I2C output mode driving low have the pullup cut off regardless of the bit.
`ifndef PULLUP_MAP_VH
`define PULLUP_MAP_VH

// Register offsets (byte addresses)
`define PUE0_OFFSET 12'h004
`define ADDR_WIDTH 12

// Field layout
`define PA_PIN_COUNT 6
`define PA_FIELD_MSB 5
`define PA_I2C_PIN_HI 3
`define PA_I2C_PIN_LO 2

// Reset value of the enable field
`define PUE0_RESET 6'h00

`endif

// ### logic/pullup_pin_ctrl.v
`timescale 1ns/10ps
`include "pullup_map.vh"

// Per-pin pullup decision, one instance per port A pin
module pullup_pin_ctrl #(
    parameter I2C_CAPABLE = 0
) (
    // Control inputs
    input wire enable,
    input wire is_output,
    input wire is_hiz,
    input wire i2c_mode,
    input wire drive_level,
    // Result
    output wire pull_on
);

    wire i2c_active;
    wire plain_allow;
    wire i2c_allow;

    // I2C path only exists on the two capable pins
    assign i2c_active = (I2C_CAPABLE != 0) && i2c_mode && is_output && !is_hiz;

    assign plain_allow = enable && !is_output && !is_hiz;

    assign i2c_allow = enable && drive_level;

    assign pull_on = i2c_active ? i2c_allow : plain_allow;

endmodule // pullup_pin_ctrl

// ### logic/port_a_pullup_enable.v
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "pullup_map.vh"

// Port A pullup enable register with per-pin pullup control
module port_a_pullup_enable (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Port A pin state from the pin mux
    input wire [`PA_FIELD_MSB:0] pin_is_output,
    input wire [`PA_FIELD_MSB:0] pin_is_hiz,
    input wire [`PA_FIELD_MSB:0] pin_i2c_mode,
    input wire [`PA_FIELD_MSB:0] pin_drive_level,
    // Pullup controls to the pads
    output reg [`PA_FIELD_MSB:0] porta_pull_on
);

    // Enable field and its next value
    reg [`PA_FIELD_MSB:0] pull_en_q;
    reg [`PA_FIELD_MSB:0] pull_en_d;
    // APB response next values and bus phase
    reg [31:0] prdata_d;
    reg pready_d;
    reg pslverr_d;
    reg phase_q;
    reg phase_d;
    // Pullup decisions ahead of the pad register
    wire [`PA_FIELD_MSB:0] pull_comb;
    // Setup cycle and address match
    wire setup;
    wire hit;
    // Access phase and write strobe
    wire access;
    wire wr_strobe;
    // Readback word
    wire [31:0] read_word;

    // Bus phase codes
    localparam PH_IDLE = 1'b0;
    localparam PH_ANSWER = 1'b1;

    // Named views of the enable field
    wire porta_pin5_pull_en = pull_en_q[5];
    wire porta_pin4_pull_en = pull_en_q[4];
    wire porta_pin3_pull_en = pull_en_q[3];
    wire porta_pin2_pull_en = pull_en_q[2];
    wire porta_pin1_pull_en = pull_en_q[1];
    wire porta_pin0_pull_en = pull_en_q[0];

    // Address match on the full byte address, no low bits ignored
    function addr_match;
        input [`ADDR_WIDTH-1:0] a;
        begin
            addr_match = (a == `PUE0_OFFSET);
        end
    endfunction

    // Setup cycle of a transfer
    assign setup = psel && !penable;

    // Address decode
    assign hit = addr_match(paddr);

    // Access phase in which this block answers
    assign access = psel && penable && pready;

    // Write lands at the end of the access phase
    assign wr_strobe = access && pwrite && hit;

    // Readback word from the named fields, upper bits zero
    assign read_word = {
        26'h0,
        porta_pin5_pull_en,
        porta_pin4_pull_en,
        porta_pin3_pull_en,
        porta_pin2_pull_en,
        porta_pin1_pull_en,
        porta_pin0_pull_en
    };

    always @* begin
        pull_en_d = pull_en_q;
        if (wr_strobe) begin
            pull_en_d = pwdata[`PA_FIELD_MSB:0];
        end
    end

    // Enable register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_en_q <= `PUE0_RESET;
        end else begin
            pull_en_q <= pull_en_d;
        end
    end

    // Bus phase: a sampled setup cycle leads to one answer cycle
    always @* begin
        phase_d = PH_IDLE;
        case (phase_q)
            PH_IDLE: begin
                if (setup) begin
                    phase_d = PH_ANSWER;
                end
            end
            PH_ANSWER: begin
                phase_d = PH_IDLE;
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    // Bus phase register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // APB response next state: ready in the answer cycle, error off the map
    always @* begin
        pready_d = (phase_d == PH_ANSWER);
        pslverr_d = pready_d && !hit;
        prdata_d = 32'h00000000;
        if (pready_d && !pwrite && hit) begin
            prdata_d = read_word;
        end
    end

    // APB response registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= pready_d;
            pslverr <= pslverr_d;
            prdata <= prdata_d;
        end
    end

    // Pins 5 and 4, plain pullups
    // pin 5
    pullup_pin_ctrl #(.I2C_CAPABLE(0)) u_pin5 (
        .enable(porta_pin5_pull_en),
        .is_output(pin_is_output[5]),
        .is_hiz(pin_is_hiz[5]),
        .i2c_mode(pin_i2c_mode[5]),
        .drive_level(pin_drive_level[5]),
        .pull_on(pull_comb[5])
    );

    pullup_pin_ctrl #(.I2C_CAPABLE(0)) u_pin4 (
        .enable(porta_pin4_pull_en),
        .is_output(pin_is_output[4]),
        .is_hiz(pin_is_hiz[4]),
        .i2c_mode(pin_i2c_mode[4]),
        .drive_level(pin_drive_level[4]),
        .pull_on(pull_comb[4])
    );

    // Pins 3 and 2, I2C capable
    // pin 3
    pullup_pin_ctrl #(.I2C_CAPABLE(1)) u_pin3 (
        .enable(porta_pin3_pull_en),
        .is_output(pin_is_output[3]),
        .is_hiz(pin_is_hiz[3]),
        .i2c_mode(pin_i2c_mode[3]),
        .drive_level(pin_drive_level[3]),
        .pull_on(pull_comb[3])
    );

    pullup_pin_ctrl #(.I2C_CAPABLE(1)) u_pin2 (
        .enable(porta_pin2_pull_en),
        .is_output(pin_is_output[2]),
        .is_hiz(pin_is_hiz[2]),
        .i2c_mode(pin_i2c_mode[2]),
        .drive_level(pin_drive_level[2]),
        .pull_on(pull_comb[2])
    );

    // Pins 1 and 0, plain pullups
    // pin 1
    pullup_pin_ctrl #(.I2C_CAPABLE(0)) u_pin1 (
        .enable(porta_pin1_pull_en),
        .is_output(pin_is_output[1]),
        .is_hiz(pin_is_hiz[1]),
        .i2c_mode(pin_i2c_mode[1]),
        .drive_level(pin_drive_level[1]),
        .pull_on(pull_comb[1])
    );

    pullup_pin_ctrl #(.I2C_CAPABLE(0)) u_pin0 (
        .enable(porta_pin0_pull_en),
        .is_output(pin_is_output[0]),
        .is_hiz(pin_is_hiz[0]),
        .i2c_mode(pin_i2c_mode[0]),
        .drive_level(pin_drive_level[0]),
        .pull_on(pull_comb[0])
    );

    // Registered pad controls, one cycle behind inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_pull_on <= 6'h00;
        end else begin
            porta_pull_on <= pull_comb;
        end
    end

endmodule // port_a_pullup_enable

// ### dv/pullup_checker_assertions.sv
`timescale 1ns/10ps
module pullup_checker (
    // Bus side
    input wire pclk, presetn, psel, penable, pwrite, pready,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    // Pin side
    input wire [5:0] pin_is_output, pin_is_hiz, pin_i2c_mode, pin_drive_level, porta_pull_on
);
    reg [5:0] fld_q;
    // Write strobe, I2C pins, expected pulls
    wire wr = psel & penable & pready & pwrite & paddr == 12'h004;
    wire [5:0] m = pin_i2c_mode & pin_is_output & ~pin_is_hiz & 6'h0c;
    wire [5:0] x = fld_q & ~pin_is_output & ~pin_is_hiz & ~m | fld_q & pin_drive_level & m;
    // Shadow of the enable field
    always @(posedge pclk or negedge presetn)
        if (!presetn) fld_q <= 6'h00;
        else if (wr) fld_q <= pwdata[5:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pull_upper: assert property (porta_pull_on[5:4] == $past(x[5:4])) else $error("pins 5:4");
    a_pull_mid: assert property (porta_pull_on[3:2] == $past(x[3:2])) else $error("pins 3:2");
    a_pull_low: assert property (porta_pull_on[1:0] == $past(x[1:0])) else $error("pins 1:0");
    a_out_off: assert property (!(porta_pull_on & $past(pin_is_hiz | pin_is_output & ~m)))
        else $error("pull on driven pin");
    a_i2c_high: assert property ((porta_pull_on | $past(~(m & pin_drive_level & fld_q))) == 6'h3f)
        else $error("i2c high pull off");
    a_i2c_low: assert property (!(porta_pull_on & $past(m & ~pin_drive_level)))
        else $error("i2c low pull on");
    a_read_back: assert property (pready & !pwrite & paddr == 12'h004 |-> prdata == {26'h0, fld_q})
        else $error("read data");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    c_write: cover property (wr);
    c_i2c_high: cover property (|(m & pin_drive_level & fld_q));
    c_i2c_low: cover property (|(m & ~pin_drive_level));
endmodule // pullup_checker
bind port_a_pullup_enable pullup_checker u_pullup_checker (.*);

// ### dv/port_a_pullup_enable_test.sv
`timescale 1ns/10ps
module port_a_pullup_enable_test;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, chk = 0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, r;
    reg [5:0] pin_is_output = 6'h00, pin_is_hiz = 6'h00, pin_i2c_mode = 6'h00;
    reg [5:0] pin_drive_level = 6'h00, fld = 6'h00, m;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [5:0] porta_pull_on;
    integer miscompares = 0, comparisons = 0, seed = 32'ha3495cec, i, n;
    reg [32:0] rd_q[$];
    reg [5:0] pl_q[$];
    port_a_pullup_enable u_port_a_pullup_enable (.*);
    initial forever #50 pclk = ~pclk;
    // Compare one bus reply: error flag and read data
    task check_bus(input [32:0] got, input [32:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t bus reply got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Compare the pad pullup controls
    task check_pull(input [5:0] got, input [5:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t pullups got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Verdict and stop
    task end_of_test;
        begin
            $display("miscompares %0d comparisons %0d", miscompares, comparisons);
            if (miscompares == 0 && comparisons > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    // APB transfer, noting the reply
    task xfer(input w, input [11:0] a, input [31:0] d, input last);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            rd_q.push_back({a != 12'h004, w | a != 12'h004 ? 32'h0 : {26'h0, fld}});
            @(posedge pclk) penable <= 1'b1;
            for (n = 0; n < 9 && !pready; n = n + 1) @(posedge pclk);
            if (!pready) begin
                miscompares = miscompares + 1;
                end_of_test;
            end
            if (w && a == 12'h004) fld = d[5:0];
            penable <= 1'b0;
            if (last) psel <= 1'b0;
        end
    endtask
    // Pin state: output, hiz, i2c, level; notes expected pulls
    task pins(input [23:0] v);
        begin
            {pin_is_output, pin_is_hiz, pin_i2c_mode, pin_drive_level} <= v;
            m = v[11:6] & v[23:18] & ~v[17:12] & 6'h0c;
            pl_q.push_back(fld & ~v[23:18] & ~v[17:12] & ~m | fld & v[5:0] & m);
            @(posedge pclk) chk <= 1'b1;
            @(posedge pclk) chk <= 1'b0;
        end
    endtask
    // Result monitor
    always @(posedge pclk) begin
        if (pready && rd_q.size() > 0) check_bus({pslverr, prdata}, rd_q.pop_front());
        if (chk && pl_q.size() > 0) check_pull(porta_pull_on, pl_q.pop_front());
    end
    // Random traffic with a reset in mid-run
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 60; i = i + 1) begin
            r = $random(seed);
            xfer(1'b0, 12'h004, 32'h0, 1'b0);
            xfer(1'b1, i % 7 ? 12'h004 : 12'h008, r, 1'b0);
            xfer(1'b0, i % 5 ? 12'h004 : 12'h000, 32'h0, 1'b1);
            r = $random(seed);
            pins(r[23:0]);
            if (i == 30) begin
                presetn <= 1'b0;
                fld = 6'h00;
                @(posedge pclk) presetn <= 1'b1;
            end
        end
        end_of_test;
    end
endmodule // port_a_pullup_enable_test
